// ===== src/sync_phase_ctrl.sv
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/10ps
module sync_phase_ctrl
    import sync_ramp_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [1:0]  avs_response,
    input  wire logic        sync_in,
    output logic             sync_sampled,
    output phase_ctrl_t      phase_ctrl
);
    // ****************************************
    // register state
    // ****************************************
    logic [7:0]  phase_cfg_q, phase_cfg_d;
    logic [7:0]  ramp_ctrl_q, ramp_ctrl_d;
    logic [15:0] offset_q, offset_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  resp_q, resp_d;
    logic        ack_q, ack_d;
    cal_state_t  cal_q, cal_d;
    logic [2:0]  div_cnt_q, div_cnt_d;
    logic        hold_q, hold_d;
    logic        divrst_q, divrst_d;
    logic [15:0] ramp_tgt;
    logic [15:0] ramp_cur;
    logic        ramp_settled;
    logic [15:0] out_q;
    logic        samp_q, rise_q, fall_q, early_q, late1_q;
    logic        hold_lvl_q;
    logic        req;

    function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
        hit = (a[9:2] == idx) && (a[1:0] == 2'b00);
    endfunction : hit

    assign req  = (avs_read | avs_write) & ~ack_q;

    // ****************************************
    // avalon slave and registers
    // ****************************************
    // one wait cycle, then ack; answer is ready when waitrequest drops
    always_comb begin
        phase_cfg_d = phase_cfg_q;
        ramp_ctrl_d = ramp_ctrl_q;
        offset_d    = offset_q;
        rdata_d     = 32'h0000_0000;
        resp_d      = 2'b00;
        ack_d       = req;
        // end of sequence drops the start bit; a write in the same cycle still wins
        if (cal_d == CAL_IDLE && cal_q == CAL_DONE)
            ramp_ctrl_d[CAL_START_BIT] = 1'b0;
        if (req && avs_write && avs_byteenable[0]) begin
            if (hit(avs_address, SYNC_PHASE_IDX)) phase_cfg_d = avs_writedata[7:0];
            else if (hit(avs_address, RAMP_CTRL_IDX)) begin
                ramp_ctrl_d = avs_writedata[7:0];
                // a running sequence cannot be cancelled by a write of zero
                if (cal_q != CAL_IDLE && cal_q != CAL_DONE)
                    ramp_ctrl_d[CAL_START_BIT] = 1'b1;
            end
            else if (hit(avs_address, OFFSET_LO_IDX)) offset_d[7:0]  = avs_writedata[7:0];
            else if (hit(avs_address, OFFSET_HI_IDX)) offset_d[15:8] = avs_writedata[7:0];
        end
        if (req) begin
            if (hit(avs_address, SYNC_PHASE_IDX)) rdata_d[7:0] = phase_cfg_q;
            else if (hit(avs_address, RAMP_CTRL_IDX)) rdata_d[7:0] = ramp_ctrl_q;
            else if (hit(avs_address, OFFSET_LO_IDX)) rdata_d[7:0] = offset_q[7:0];
            else if (hit(avs_address, OFFSET_HI_IDX)) rdata_d[7:0] = offset_q[15:8];
            else if (hit(avs_address, STATUS_IDX))
                rdata_d = {13'h0000, ramp_settled, hold_q, divrst_q, ramp_cur};
            else resp_d = 2'b10;                 // slave error for unmapped words
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            phase_cfg_q <= SYNC_PHASE_RST;
            ramp_ctrl_q <= RAMP_CTRL_RST;
            offset_q    <= 16'h0000;
            rdata_q     <= 32'h0000_0000;
            resp_q      <= 2'b00;
            ack_q       <= 1'b0;
        end else begin
            phase_cfg_q <= phase_cfg_d;
            ramp_ctrl_q <= ramp_ctrl_d;
            offset_q    <= offset_d;
            rdata_q     <= rdata_d;
            resp_q      <= resp_d;
            ack_q       <= ack_d;
        end
    end

    // ****************************************
    // calibration sequencer
    // ****************************************
    always_comb begin
        cal_d     = cal_q;
        div_cnt_d = div_cnt_q;
        hold_d    = hold_q;
        divrst_d  = 1'b0;
        case (cal_q)
            CAL_IDLE: if (ramp_ctrl_q[CAL_START_BIT]) begin
                hold_d = 1'b1;
                cal_d  = CAL_ZERO;
            end
            CAL_ZERO: if (ramp_settled) begin
                cal_d     = CAL_DIVRST;
                div_cnt_d = 3'(DIV_RST_CYC);
            end
            CAL_DIVRST: begin
                divrst_d  = 1'b1;
                div_cnt_d = div_cnt_q - 3'h1;
                if (div_cnt_q == 3'h1) cal_d = CAL_RAMP;
            end
            CAL_RAMP: if (ramp_settled) cal_d = CAL_DONE;
            CAL_DONE: begin
                hold_d = 1'b0;
                cal_d  = CAL_IDLE;
            end
            default: cal_d = CAL_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cal_q     <= CAL_IDLE;
            div_cnt_q <= 3'h0;
            hold_q    <= 1'b0;
            divrst_q  <= 1'b0;
        end else begin
            cal_q     <= cal_d;
            div_cnt_q <= div_cnt_d;
            hold_q    <= hold_d;
            divrst_q  <= divrst_d;
        end
    end

    // ramp target: zero during the first leg, programmed value otherwise
    assign ramp_tgt = (cal_q == CAL_ZERO) ? 16'h0000 : offset_q;

    offset_ramper u_ramper (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .target  (ramp_tgt),
        .current (ramp_cur),
        .settled (ramp_settled)
    );

    // ****************************************
    // outputs and sync sampling
    // ****************************************
    // visible offset frozen while held, so the internal dip stays hidden
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            out_q      <= 16'h0000;
            hold_lvl_q <= 1'b0;
        end else begin
            hold_lvl_q <= hold_q;
            if (!hold_q) out_q <= ramp_cur;
        end
    end

    // rise and fall samples give the half interval positions
    always_ff @(negedge ref_clk) begin
        if (!rst_n) fall_q <= 1'b0;
        else        fall_q <= sync_in;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rise_q  <= 1'b0;
            early_q <= 1'b0;
            late1_q <= 1'b0;
            samp_q  <= 1'b0;
        end else begin
            rise_q  <= sync_in;
            early_q <= rise_q;
            late1_q <= fall_q;
            // output grid is fixed: a later sample point means a shorter path
            case (phase_cfg_q[PHASE_LSB +: 2])
                2'b00:   samp_q <= late1_q;
                2'b01:   samp_q <= early_q;
                2'b10:   samp_q <= fall_q;
                2'b11:   samp_q <= rise_q;
                default: samp_q <= late1_q;
            endcase
        end
    end

    assign avs_readdata        = rdata_q;
    assign avs_response        = resp_q;
    assign avs_waitrequest     = ~ack_q;
    assign sync_sampled        = samp_q;
    assign phase_ctrl          = '{holdover: hold_lvl_q, div_reset: divrst_q, phase_offset: out_q};
endmodule : sync_phase_ctrl

// ===== inc/sync_ramp_pkg.sv
// Contract
// - two-bit code shifts sync sampling point
// - on target: sync fall meets clock fall
// - bit clear: offset changes ramp gradually
// - output phase unchanged externally during calibration
package sync_ramp_pkg;
    // ****************************************
    // register map (word index, byte = 4*idx)
    // ****************************************
    localparam logic [7:0] SYNC_PHASE_IDX   = 8'h7B;
    localparam logic [7:0] RAMP_CTRL_IDX    = 8'h7C;
    localparam logic [7:0] OFFSET_LO_IDX    = 8'h70;
    localparam logic [7:0] OFFSET_HI_IDX    = 8'h71;
    localparam logic [7:0] STATUS_IDX       = 8'h7E;
    localparam logic [7:0] SYNC_PHASE_RST   = 8'h00;
    localparam logic [7:0] RAMP_CTRL_RST    = 8'h2B;
    localparam int         CAL_START_BIT    = 7;
    localparam int         PHASE_LSB        = 0;
    // ****************************************
    // timing: one ramp step per interval
    // ****************************************
    localparam int         CLK_MHZ          = 40;
    localparam int         RAMP_STEP_NS     = 100;
    localparam int         RAMP_STEP_CYC    = (RAMP_STEP_NS * CLK_MHZ + 999) / 1000;
    localparam logic [15:0] RAMP_INC        = 16'h0001;
    localparam int         DIV_RST_CYC      = 4;

    typedef enum { CAL_IDLE, CAL_ZERO, CAL_DIVRST, CAL_RAMP, CAL_DONE } cal_state_t;

    typedef struct packed {
        logic        holdover;
        logic        div_reset;
        logic [15:0] phase_offset;
    } phase_ctrl_t;
endpackage : sync_ramp_pkg

// ===== src/offset_ramper.sv
`timescale 1ns/10ps
// steps current offset toward target by one increment per tick
module offset_ramper
    import sync_ramp_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] target,
    output logic      [15:0] current,
    output logic             settled
);
    logic [15:0] cur_q, cur_d;
    logic [7:0]  tick_q, tick_d;

    // ****************************************
    // ramp stepping
    // ****************************************
    always_comb begin
        cur_d  = cur_q;
        tick_d = tick_q + 8'h01;
        if (tick_q == 8'(RAMP_STEP_CYC - 1)) begin
            tick_d = 8'h00;
            // signed step so wrap is never taken as a jump
            if ($signed(target - cur_q) > 0) cur_d = cur_q + RAMP_INC;
            else if (target != cur_q) cur_d = cur_q - RAMP_INC;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cur_q  <= 16'h0000;
            tick_q <= 8'h00;
        end else begin
            cur_q  <= cur_d;
            tick_q <= tick_d;
        end
    end

    assign current = cur_q;
    assign settled = (cur_q == target);
endmodule : offset_ramper

// ===== test/sync_ramp_asserts.sv
`timescale 1ns/10ps
// ****************
// bus and phase checks
// ****************
module sync_ramp_asserts
    import sync_ramp_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  avs_response,
    input wire phase_ctrl_t phase_ctrl
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic ack;
    logic map;
    logic hold;
    logic [15:0] ofs;
    // short names keep each property to three lines at most
    assign ack = !avs_waitrequest;
    assign map = (avs_address[1:0] == 2'b00) && (avs_address[9:2] inside
        {OFFSET_LO_IDX, OFFSET_HI_IDX, SYNC_PHASE_IDX, RAMP_CTRL_IDX, STATUS_IDX});
    assign hold = phase_ctrl.holdover;
    assign ofs = phase_ctrl.phase_offset;
    a_ack_single: assert property (ack |=> !ack) else $error("ack too long");
    a_ack_latency: assert property ($rose(avs_read | avs_write) |=> ack) else $error("late ack");
    a_unmapped_err: assert property (ack && !map |-> avs_response == 2'b10
        && avs_readdata == 32'h0) else $error("unmapped not refused");
    a_mapped_ok: assert property (ack && map |-> avs_response == 2'b00) else $error("bad resp");
    a_hold_freeze: assert property (hold && $past(hold) |-> $stable(ofs))
        else $error("offset moved in holdover");
    a_divrst_span: assert property ($rose(phase_ctrl.div_reset) |->
        phase_ctrl.div_reset[*4] ##1 !phase_ctrl.div_reset) else $error("divider reset span");
    a_divrst_hold: assert property (phase_ctrl.div_reset |-> hold) else $error("reset no hold");
    a_cal_enter: assert property (ack && avs_write && avs_address[9:2] == 8'h7C
        && avs_byteenable[0] && avs_writedata[7] && !hold |-> ##[1:3] hold)
        else $error("no holdover");
    a_ramp_step: assert property (!hold && !$past(hold) && $changed(ofs)
        |-> (ofs - $past(ofs)) inside {16'h0001, 16'hFFFF}) else $error("ramp jump");
    a_ramp_gap: assert property (!hold && !$past(hold) && $changed(ofs)
        |=> $stable(ofs)[*3]) else $error("ramp too fast");
    // main scenarios reached
    cover property (ack && !map);
    cover property ($rose(phase_ctrl.div_reset));
    cover property ($fell(hold));
endmodule : sync_ramp_asserts
bind sync_phase_ctrl sync_ramp_asserts sync_ramp_asserts_inst (.ref_clk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .avs_response, .phase_ctrl);

// ===== test/sync_source.sv
`timescale 1ns/10ps
// ****************
// frame sync pulse source
// ****************
module sync_source (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    output logic      sync_in
);
    int cnt_q;
    // edges launched on the falling clock edge, so the input fall meets the clock fall
    always @(negedge ref_clk) begin
        cnt_q <= rst_n ? (cnt_q + 1) % 40 : 0;
        sync_in <= rst_n && (cnt_q < 16);
    end
endmodule : sync_source

// ===== test/sync_phase_ctrl_test.sv
`timescale 1ns/10ps
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin n_fail++; \
    $display("wrong value %s exp %0h got %0h", nm, e, s); end end
module sync_phase_ctrl_test
    import sync_ramp_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rst_n, avs_read, avs_write, sync_in, sync_sampled, avs_waitrequest;
    logic [9:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, v, d;
    logic [3:0]  avs_byteenable;
    logic [1:0]  avs_response, r;
    logic [15:0] t;
    phase_ctrl_t phase_ctrl;
    int          n_fail, comparisons, seed, n;
    sync_phase_ctrl sync_phase_ctrl_inst (.ref_clk, .rst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .avs_response, .sync_in, .sync_sampled, .phase_ctrl);
    sync_source sync_source_inst (.ref_clk, .rst_n, .sync_in);
    always #12.5 ref_clk = ~ref_clk;
    // one bus cycle; held until waitrequest is seen low at a rising edge,
    // answer taken at that edge, released right after it
    task automatic bus(input int w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge ref_clk);
        avs_write <= (w != 0);
        avs_read <= (w == 0);
        avs_address <= {idx, 2'b00};
        avs_writedata <= wd;
        do @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        r = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    // sync edges come on the falling clock edge; output grid is fixed,
    // so a later sample point shows the edge no later; codes 10 and 11 a cycle sooner
    function automatic int samp_delay(input logic [1:0] code);
        case (code)
            2'b00, 2'b01: return 4;
            default:      return 3;
        endcase
    endfunction : samp_delay
    // start bit drops, the rest of the control byte survives
    function automatic logic [31:0] cal_done(input logic [7:0] c);
        return {24'h0, c & 8'h7F};
    endfunction : cal_done
    task final_report;
        if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // watchdog: whole run is under a thousand cycles
    initial begin
        #300us;
        n_fail++;
        final_report();
    end
    initial begin
        {rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {n_fail, comparisons} = '0;
        avs_byteenable = 4'hF;
        seed = 9;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus(0, SYNC_PHASE_IDX, 0);
        `CHK("phase reset", 32'h00, v)
        bus(0, RAMP_CTRL_IDX, 0);
        `CHK("ramp reset", 32'h2B, v)
        bus(0, 8'hFF, 0);
        `CHK("unmapped", 2'b10, r)
        // every phase code, random upper bits; sampled sync must follow the source
        for (int c = 0; c < 4; c++) begin
            d = ($random(seed) & 32'hC0) | c;
            bus(1, SYNC_PHASE_IDX, d);
            bus(0, SYNC_PHASE_IDX, 0);
            `CHK("phase code", d, v)
            @(posedge sync_in);
            n = 0;
            do begin
                @(posedge ref_clk);
                n++;
            end while (sync_sampled !== 1'b1 && n < 20);
            `CHK("sync delay", samp_delay(c[1:0]), n)
            repeat (4) @(posedge ref_clk);
            `CHK("sampled high", 1'b1, sync_sampled)
            @(negedge sync_in);
            repeat (8) @(posedge ref_clk);
            `CHK("sampled low", 1'b0, sync_sampled)
        end
        avs_byteenable <= 4'h0;
        bus(1, SYNC_PHASE_IDX, 32'h41);
        avs_byteenable <= 4'hF;
        bus(0, SYNC_PHASE_IDX, 0);
        `CHK("lane off", d, v)
        // offset change ramps one step at a time
        t = 16'h8 + 16'($random(seed) & 15);
        bus(1, OFFSET_HI_IDX, 0);
        bus(1, OFFSET_LO_IDX, {16'h0, t});
        repeat (8) @(posedge ref_clk);
        `CHK("ramping", 1'b1, phase_ctrl.phase_offset < t)
        repeat (4 * t + 20) @(posedge ref_clk);
        `CHK("ramp end", t, phase_ctrl.phase_offset)
        bus(0, STATUS_IDX, 0);
        `CHK("status", {3'b100, t}, v[18:0])
        // calibration: holdover, self-clearing start bit, no visible step
        bus(1, RAMP_CTRL_IDX, 32'hAB);
        repeat (2) @(posedge ref_clk);
        `CHK("holdover", 1'b1, phase_ctrl.holdover)
        n = 0;
        do begin
            bus(0, RAMP_CTRL_IDX, 0);
            n++;
        end while (v[7] !== 1'b0 && n < 200);
        `CHK("start clear", cal_done(8'hAB), v)
        repeat (2) @(posedge ref_clk);
        `CHK("hold off", 1'b0, phase_ctrl.holdover)
        `CHK("no step", t, phase_ctrl.phase_offset)
        final_report();
    end
endmodule : sync_phase_ctrl_test
